// ===== hw/data_mem_pkg.sv
// package: offsets, widths and reset values for the sectored data memory
// assumes: used by the data memory top and its address resolver
package data_mem_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int DATA_W = 8;
   localparam int ADDR_W = 9;
   localparam int GP_DEPTH = 256;
   // ****************************************
   // special-function offsets within a sector
   // ****************************************
   localparam logic [7:0] OFS_INDIRECT_PORT_SECTOR0 = 8'h00;
   localparam logic [7:0] OFS_POINTER_SECTOR0 = 8'h01;
   localparam logic [7:0] OFS_INDIRECT_PORT_A = 8'h02;
   localparam logic [7:0] OFS_POINTER_A_LOW = 8'h03;
   localparam logic [7:0] OFS_POINTER_A_SECTOR = 8'h04;
   localparam logic [7:0] OFS_INDIRECT_PORT_B = 8'h0C;
   localparam logic [7:0] OFS_POINTER_B_LOW = 8'h0D;
   localparam logic [7:0] OFS_POINTER_B_SECTOR = 8'h0E;
   localparam logic [7:0] OFS_SPECIAL_LAST = 8'h7F;
   localparam logic [7:0] OFS_GENERAL_FIRST = 8'h80;
   // ****************************************
   // reset and read values
   // ****************************************
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] UNUSED_READ = 8'h00;
   // ****************************************
   // access kinds from the core
   // ****************************************
   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_SET_BIT = 2'b01,
      OP_CLR_BIT = 2'b11,
      OP_INC = 2'b10
   } op_e;
endpackage : data_mem_pkg

// ===== hw/resolve_if.sv
// interface: carries an access address to the resolver and the resolved target back
// assumes: both ends share one clock; signals are combinational
`timescale 1ns/1ps
`default_nettype none
interface resolve_if;
   logic [8:0] req_addr;
   logic [7:0] ptr0;
   logic [7:0] ptr_a_low;
   logic [7:0] ptr_a_sector;
   logic [7:0] ptr_b_low;
   logic [7:0] ptr_b_sector;
   logic [8:0] eff_addr;
   logic eff_is_port;
   modport top (output req_addr, ptr0, ptr_a_low, ptr_a_sector, ptr_b_low, ptr_b_sector,
                input eff_addr, eff_is_port);
   modport resolver (input req_addr, ptr0, ptr_a_low, ptr_a_sector, ptr_b_low, ptr_b_sector,
                     output eff_addr, eff_is_port);
endinterface : resolve_if
`default_nettype wire

// ===== hw/addr_resolver.sv
// module: maps a direct or extended address through the indirect ports
// assumes: pointer values come straight from the top's pointer registers
`timescale 1ns/1ps
`default_nettype none
module addr_resolver (
   resolve_if.resolver rif
);
   logic [7:0] ofs;
   logic sect;
   // ****************************************
   // redirect the three virtual ports
   // ****************************************
   always_comb begin
      ofs = rif.req_addr[7:0];
      sect = rif.req_addr[8];
      rif.eff_addr = rif.req_addr;
      rif.eff_is_port = 1'b0;
      // RULE7 port redirects access
      // ports exist in sector 0 only; sector 1 low offsets are plain unused space
      case ({sect, ofs})
         // RULE8 sector 0 only
         {1'b0, data_mem_pkg::OFS_INDIRECT_PORT_SECTOR0}: begin
            rif.eff_addr = {1'b0, rif.ptr0};
            rif.eff_is_port = 1'b1;
         end
         // RULE9 pair chooses sector
         {1'b0, data_mem_pkg::OFS_INDIRECT_PORT_A}: begin
            rif.eff_addr = {rif.ptr_a_sector[0], rif.ptr_a_low};
            rif.eff_is_port = 1'b1;
         end
         {1'b0, data_mem_pkg::OFS_INDIRECT_PORT_B}: begin
            rif.eff_addr = {rif.ptr_b_sector[0], rif.ptr_b_low};
            rif.eff_is_port = 1'b1;
         end
         default: begin
            rif.eff_addr = {sect, ofs};
            rif.eff_is_port = 1'b0;
         end
      endcase
   end
endmodule : addr_resolver
`default_nettype wire

// ===== hw/data_memory.sv
// file: sectored data memory with pointers and indirect access ports
// assumes: the core drives one access per cycle; read data registered one cycle later
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - offsets 00H to 7FH in each sector decode as special-function space.
// RULE2 - offsets 80H to FFH in sectors 0 and 1 hold 256 bytes of general RAM.
// RULE3 - indirect access takes its sector from the high pointer byte and its offset from the low one.
// RULE4 - extended addresses carry 9 bits, the top bit the sector and the low byte the offset.
// RULE5 - extended access reaches every sector without pointers; direct access reaches sector 0 only.
// RULE6 - unused special-function locations read as 00H.
// RULE7 - accesses to a virtual port act on the pointed-to location instead.
// RULE8 - the first port with its single pointer reaches sector 0 only.
// RULE9 - the second and third ports use a low and high pointer pair and reach any sector.
// RULE10 - a port pointing at a port reads 00H and ignores writes.
// RULE11 - five pointer bytes are real registers, readable, writable, incrementable.
// RULE12 - general RAM is fully read/write with single-bit set and clear.
// RULE13 - protected special-function locations ignore writes.
// RULE14 - an indirect access takes the same cycle as a direct one, using current pointer values.
module data_memory (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // access from the core
   input wire logic acc_en,
   input wire logic acc_wr,
   input wire logic acc_ext,
   input wire logic [8:0] acc_addr,
   input wire logic [1:0] acc_op,
   input wire logic [2:0] acc_bit,
   input wire logic [7:0] acc_wdata,
   // protected special-function values from the rest of the core
   input wire logic [7:0] prot_rdata,
   // answers
   output logic [7:0] rdata,
   output logic rvalid,
   output logic wr_blocked
);
   // ****************************************
   // storage
   // ****************************************
   logic [7:0] gp_mem [0:data_mem_pkg::GP_DEPTH-1];
   logic [7:0] ptr0_reg, ptr0_next;
   logic [7:0] ptr_a_low_reg, ptr_a_low_next;
   logic [7:0] ptr_a_sector_reg, ptr_a_sector_next;
   logic [7:0] ptr_b_low_reg, ptr_b_low_next;
   logic [7:0] ptr_b_sector_reg, ptr_b_sector_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic blocked_reg, blocked_next;
   logic [8:0] lookup_addr;
   logic [8:0] eff;
   logic via_port;
   logic [7:0] ofs;
   logic gp_hit;
   logic [7:0] old_val;
   logic [7:0] new_val;
   logic gp_we;
   logic [7:0] gp_index;
   resolve_if rif ();
   // ****************************************
   // address resolution
   // ****************************************
   // RULE4 nine-bit extended address
   // standard instructions see sector 0 only
   assign lookup_addr = acc_ext ? acc_addr : {1'b0, acc_addr[7:0]};
   assign rif.req_addr = lookup_addr;
   // RULE14 live pointer values
   // RULE3 sector from high byte
   assign rif.ptr0 = ptr0_reg;
   assign rif.ptr_a_low = ptr_a_low_reg;
   assign rif.ptr_a_sector = ptr_a_sector_reg;
   assign rif.ptr_b_low = ptr_b_low_reg;
   assign rif.ptr_b_sector = ptr_b_sector_reg;
   addr_resolver u_resolver (
      .rif(rif)
   );
   assign eff = rif.eff_addr;
   assign via_port = rif.eff_is_port;
   assign ofs = eff[7:0];
   // RULE1 special area below 80H
   // RULE2 general area from 80H
   assign gp_hit = (ofs >= data_mem_pkg::OFS_GENERAL_FIRST);
   // RULE2 index folds sector into ram
   assign gp_index = {eff[8], ofs[6:0]};
   // ****************************************
   // current value of the target location
   // ****************************************
   always_comb begin
      old_val = data_mem_pkg::UNUSED_READ;
      if (gp_hit) begin
         old_val = gp_mem[gp_index];
      end else if (eff[8] == 1'b0) begin
         case (ofs)
            // RULE11 pointers read back
            data_mem_pkg::OFS_POINTER_SECTOR0: old_val = ptr0_reg;
            data_mem_pkg::OFS_POINTER_A_LOW: old_val = ptr_a_low_reg;
            data_mem_pkg::OFS_POINTER_A_SECTOR: old_val = ptr_a_sector_reg;
            data_mem_pkg::OFS_POINTER_B_LOW: old_val = ptr_b_low_reg;
            data_mem_pkg::OFS_POINTER_B_SECTOR: old_val = ptr_b_sector_reg;
            // RULE10 ports have no storage
            data_mem_pkg::OFS_INDIRECT_PORT_SECTOR0,
            data_mem_pkg::OFS_INDIRECT_PORT_A,
            data_mem_pkg::OFS_INDIRECT_PORT_B: old_val = data_mem_pkg::UNUSED_READ;
            // RULE13 protected values passed through
            default: old_val = prot_rdata;
         endcase
      end else begin
         // RULE6 unused sector 1 special reads zero
         old_val = data_mem_pkg::UNUSED_READ;
      end
   end
   // ****************************************
   // modify: write, bit set, bit clear, increment
   // ****************************************
   always_comb begin
      new_val = acc_wdata;
      case (acc_op)
         // RULE12 single-bit set and clear
         data_mem_pkg::OP_SET_BIT: new_val = old_val | (8'h01 << acc_bit);
         data_mem_pkg::OP_CLR_BIT: new_val = old_val & ~(8'h01 << acc_bit);
         // RULE11 increment through the datapath
         data_mem_pkg::OP_INC: new_val = old_val + 8'h01;
         default: new_val = acc_wdata;
      endcase
   end
   // ****************************************
   // pointer registers and answers
   // ****************************************
   always_comb begin
      ptr0_next = ptr0_reg;
      ptr_a_low_next = ptr_a_low_reg;
      ptr_a_sector_next = ptr_a_sector_reg;
      ptr_b_low_next = ptr_b_low_reg;
      ptr_b_sector_next = ptr_b_sector_reg;
      rdata_next = rdata_reg;
      rvalid_next = 1'b0;
      blocked_next = 1'b0;
      gp_we = 1'b0;
      if (acc_en && !acc_wr) begin
         // RULE5 any sector by extended, sector 0 only by direct
         rdata_next = old_val;
         rvalid_next = 1'b1;
      end else if (acc_en && acc_wr) begin
         if (gp_hit) begin
            gp_we = 1'b1;
         end else if (eff[8] == 1'b0) begin
            case (ofs)
               // RULE11 pointers are real registers
               data_mem_pkg::OFS_POINTER_SECTOR0: ptr0_next = new_val;
               data_mem_pkg::OFS_POINTER_A_LOW: ptr_a_low_next = new_val;
               data_mem_pkg::OFS_POINTER_A_SECTOR: ptr_a_sector_next = new_val;
               data_mem_pkg::OFS_POINTER_B_LOW: ptr_b_low_next = new_val;
               data_mem_pkg::OFS_POINTER_B_SECTOR: ptr_b_sector_next = new_val;
               // RULE10 port writes dropped
               data_mem_pkg::OFS_INDIRECT_PORT_SECTOR0,
               data_mem_pkg::OFS_INDIRECT_PORT_A,
               data_mem_pkg::OFS_INDIRECT_PORT_B: blocked_next = 1'b1;
               // RULE13 protected locations not changed
               default: blocked_next = 1'b1;
            endcase
         end else begin
            // unused sector 1 special locations ignore writes
            blocked_next = 1'b1;
         end
      end
      // flag when the redirect itself landed on nothing
      if (acc_en && acc_wr && via_port && !gp_hit && blocked_next) begin
         blocked_next = 1'b1;
      end
   end
   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ptr0_reg <= data_mem_pkg::POINTER_RESET;
         ptr_a_low_reg <= data_mem_pkg::POINTER_RESET;
         ptr_a_sector_reg <= data_mem_pkg::POINTER_RESET;
         ptr_b_low_reg <= data_mem_pkg::POINTER_RESET;
         ptr_b_sector_reg <= data_mem_pkg::POINTER_RESET;
         rdata_reg <= data_mem_pkg::UNUSED_READ;
         rvalid_reg <= 1'b0;
         blocked_reg <= 1'b0;
      end else begin
         ptr0_reg <= ptr0_next;
         ptr_a_low_reg <= ptr_a_low_next;
         ptr_a_sector_reg <= ptr_a_sector_next;
         ptr_b_low_reg <= ptr_b_low_next;
         ptr_b_sector_reg <= ptr_b_sector_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         blocked_reg <= blocked_next;
      end
   end
   // ram has no reset; contents are undefined at power-up
   always_ff @(posedge clock) begin
      if (gp_we) begin
         gp_mem[gp_index] <= new_val;
      end
   end
   assign rdata = rdata_reg;
   assign rvalid = rvalid_reg;
   assign wr_blocked = blocked_reg;
endmodule : data_memory
`default_nettype wire

// ===== tb/dm_checker.sv
// checker: timing and refusal properties at the data memory ports
// assumes: bound onto data_memory; one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module dm_checker (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // access
   input wire logic acc_en,
   input wire logic acc_wr,
   input wire logic acc_ext,
   input wire logic [8:0] acc_addr,
   input wire logic [7:0] prot_rdata,
   // answers
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic wr_blocked
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // taken requests, split by kind and target
   sequence s_rd; acc_en && !acc_wr; endsequence
   sequence s_wr; acc_en && acc_wr; endsequence
   sequence s_far; acc_ext && acc_addr[8] && !acc_addr[7]; endsequence
   sequence s_prot; !acc_ext && acc_addr[7:0] == 8'h05; endsequence
   a_read_answer: assert property (s_rd |=> rvalid)
      else $error("read not answered next cycle");
   a_valid_cause: assert property (!(acc_en && !acc_wr) |=> !rvalid)
      else $error("answer without a read");
   a_read_clean: assert property (s_rd |=> !wr_blocked)
      else $error("read flagged as refused write");
   a_ram_write: assert property (s_wr ##0 acc_addr[7] |=> !wr_blocked)
      else $error("general write refused");
   a_far_refuse: assert property (s_wr ##0 s_far |=> wr_blocked)
      else $error("sector one special write accepted");
   a_far_zero: assert property (s_rd ##0 s_far |=> rdata == 8'h00)
      else $error("sector one special read not zero");
   a_prot_read: assert property (s_rd ##0 s_prot |=> rdata == $past(prot_rdata))
      else $error("protected value not returned");
   a_prot_keep: assert property (s_wr ##0 s_prot |=> wr_blocked)
      else $error("protected write accepted");
   a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
      else $error("read data moved without a read");
endmodule : dm_checker
`default_nettype wire

// ===== tb/core_model.sv
// model: core execution unit, one data memory access per cycle
// assumes: tasks are called on a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module core_model (
   // clock
   input wire logic clock,
   // access
   output logic acc_en,
   output logic acc_wr,
   output logic acc_ext,
   output logic [8:0] acc_addr,
   output logic [1:0] acc_op,
   output logic [2:0] acc_bit,
   output logic [7:0] acc_wdata
);
   // drive one access, held across the rising edge that takes it
   task automatic issue(input logic w, x, input logic [8:0] a, input logic [1:0] o, input logic [2:0] b,
                        input logic [7:0] d);
      {acc_en, acc_wr, acc_ext, acc_addr, acc_op, acc_bit, acc_wdata} = {1'b1, w, x, a, o, b, d};
      @(negedge clock);
   endtask : issue
   // release: enable dropped, address and data inverted so a stale value never looks valid
   task automatic idle();
      {acc_en, acc_addr, acc_wdata} = {1'b0, ~acc_addr, ~acc_wdata};
      @(negedge clock);
   endtask : idle
   // quiet at time zero
   initial begin
      {acc_en, acc_wr, acc_ext, acc_addr, acc_op, acc_bit, acc_wdata} = '0;
   end
endmodule : core_model
`default_nettype wire

// ===== tb/tb.sv
// bench: drives the data memory through the core model, checks answers
// assumes: package, design, checker and core model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock, rstn, acc_en, acc_wr, acc_ext, rvalid, wr_blocked, e, s;
   logic [8:0] acc_addr;
   logic [1:0] acc_op;
   logic [2:0] acc_bit;
   logic [7:0] acc_wdata, prot_rdata, rdata, k;
   logic [7:0] ram [256];
   logic [31:0] seed, r;
   int fail_count, total_checks;
   logic [7:0] po [3] = '{8'h00, 8'h02, 8'h0c};
   logic [7:0] lo [3] = '{8'h01, 8'h03, 8'h0d};
   logic [7:0] hi [3] = '{8'h01, 8'h04, 8'h0e};
   core_model i_core_model (.clock(clock), .acc_en(acc_en), .acc_wr(acc_wr), .acc_ext(acc_ext),
      .acc_addr(acc_addr), .acc_op(acc_op), .acc_bit(acc_bit), .acc_wdata(acc_wdata));
   data_memory i_data_memory (.clock(clock), .rstn(rstn), .acc_en(acc_en), .acc_wr(acc_wr),
      .acc_ext(acc_ext), .acc_addr(acc_addr), .acc_op(acc_op), .acc_bit(acc_bit), .acc_wdata(acc_wdata),
      .prot_rdata(prot_rdata), .rdata(rdata), .rvalid(rvalid), .wr_blocked(wr_blocked));
   // 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // xorshift source from a fixed start
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // expected byte after a write or read-modify-write
   function automatic logic [7:0] apply(logic [1:0] o, logic [7:0] v, logic [2:0] b, logic [7:0] d);
      case (o)
         data_mem_pkg::OP_SET_BIT: return v | (8'h01 << b);
         data_mem_pkg::OP_CLR_BIT: return v & ~(8'h01 << b);
         data_mem_pkg::OP_INC: return v + 8'h01;
         default: return d;
      endcase
   endfunction : apply
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   // read, then look at the answer in its one valid cycle
   task automatic rd(input logic x, input logic [8:0] a, input logic [7:0] exp);
      i_core_model.issue(1'b0, x, a, 2'b00, 3'h0, 8'h00);
      chk({7'h00, rvalid}, 8'h01);
      chk(rdata, exp);
   endtask : rd
   task automatic wr(input logic x, input logic [8:0] a, input logic [1:0] o, input logic [2:0] b,
                     input logic [7:0] d, input logic blk);
      i_core_model.issue(1'b1, x, a, o, b, d);
      chk({7'h00, wr_blocked}, {7'h00, blk});
   endtask : wr
   // main sequence; ram is never reset, so it is filled first
   initial begin
      {seed, rstn, prot_rdata, fail_count, total_checks} = {32'h0000_8cf4, 1'b0, 8'h00, 64'h0};
      repeat (6) @(negedge clock);
      rstn = 1'b1;
      chk({rdata[6:0], rvalid}, 8'h00);
      chk({7'h00, wr_blocked}, 8'h00);
      for (int p = 0; p < 3; p++) begin
         rd(1'b0, {1'b0, lo[p]}, 8'h00);
         rd(1'b0, {1'b0, hi[p]}, 8'h00);
      end
      $display("test reset done");
      for (int i = 0; i < 256; i++) begin
         ram[i] = rnd();
         wr(i[7], {i[7], 1'b1, i[6:0]}, 2'b00, 3'h0, ram[i], 1'b0);
      end
      $display("test fill done");
      for (int i = 0; i < 400; i++) begin
         r = rnd();
         e = r[9];
         k = {e & r[8], r[6:0]};
         if (r[10]) rd(e, {r[8], 1'b1, r[6:0]}, ram[k]);
         else begin
            ram[k] = apply(r[12:11], ram[k], r[15:13], r[23:16]);
            wr(e, {r[8], 1'b1, r[6:0]}, r[12:11], r[15:13], r[23:16], 1'b0);
         end
      end
      $display("test random done");
      for (int p = 0; p < 3; p++) begin
         r = rnd();
         s = (p == 0) ? 1'b0 : r[8];
         k = {s, r[6:0]};
         wr(1'b0, {1'b0, lo[p]}, 2'b00, 3'h0, {1'b1, r[6:0]}, 1'b0);
         if (p > 0) wr(1'b0, {1'b0, hi[p]}, 2'b00, 3'h0, {7'h00, s}, 1'b0);
         rd(1'b0, {1'b0, po[p]}, ram[k]);
         ram[k] = r[23:16];
         wr(1'b0, {1'b0, po[p]}, 2'b00, 3'h0, r[23:16], 1'b0);
         rd(s, {s, 1'b1, r[6:0]}, ram[k]);
         wr(1'b0, {1'b0, lo[p]}, data_mem_pkg::OP_INC, 3'h0, 8'h00, 1'b0);
         rd(1'b0, {1'b0, lo[p]}, {1'b1, r[6:0]} + 8'h01);
      end
      $display("test ports done");
      wr(1'b0, 9'h001, 2'b00, 3'h0, 8'h02, 1'b0);
      rd(1'b0, 9'h000, 8'h00);
      wr(1'b0, 9'h000, 2'b00, 3'h0, 8'h5a, 1'b1);
      r = rnd();
      prot_rdata = r[7:0];
      rd(1'b0, 9'h005, r[7:0]);
      wr(1'b0, 9'h005, 2'b00, 3'h0, r[15:8], 1'b1);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         rd(1'b1, {2'b10, r[6:0]}, 8'h00);
         wr(1'b1, {2'b10, r[6:0]}, 2'b00, 3'h0, r[15:8], 1'b1);
      end
      i_core_model.idle();
      $display("test special done");
      close_out();
   end
endmodule : tb
bind data_memory dm_checker i_dm_checker (.clock(clock), .rstn(rstn), .acc_en(acc_en), .acc_wr(acc_wr),
   .acc_ext(acc_ext), .acc_addr(acc_addr), .prot_rdata(prot_rdata), .rdata(rdata), .rvalid(rvalid),
   .wr_blocked(wr_blocked));
`default_nettype wire
